// [dv/data_mem_model.sv]
`timescale 1ns/10ps
// ====================================
// data memory beside the core
module data_mem_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [4096];
  // read is combinational; cells never set read unknown, so a wrong address shows
  assign o_rdata = mem[i_addr];
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

// [dv/table_xor_exec_chk.sv]
`timescale 1ns/10ps
// ====================================
// port checker
module table_xor_exec_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_rd,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic        i_instr_two_word,
  input wire logic [7:0]  i_file_rdata,
  input wire logic        o_instr_ready,
  input wire logic        o_discard,
  input wire logic [7:0]  o_rdata,
  input wire logic [11:0] o_file_addr,
  input wire logic        o_file_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a discarded word is not a real take, so it starts nothing
  wire tk = o_instr_ready && i_instr_valid && !o_discard;
  sequence tst_take;
    tk && i_instr[15:9] == 7'h33;
  endsequence
  sequence tbl_take;
    tk && i_instr[15:2] == 14'h0003;
  endsequence
  a_skip_zero: assert property (tst_take ##1 i_file_rdata == 8'h00 |-> ##3 o_discard)
    else $error("zero operand did not skip");
  a_skip_none: assert property (tst_take ##1 i_file_rdata != 8'h00 |-> ##3 !o_discard)
    else $error("nonzero operand skipped");
  a_skip_two: assert property (o_discard && i_instr_two_word && o_instr_ready |-> ##4 o_discard)
    else $error("second word not skipped");
  a_tbl_cycles: assert property (tbl_take |=> !o_instr_ready [*7])
    else $error("table write shorter than two cycles");
  a_ready_gap: assert property (o_instr_ready |=> !o_instr_ready [*3])
    else $error("take slots closer than four clocks");
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_we_dest: assert property (tk && i_instr[15:9] == 7'h0d |-> ##3 o_file_we)
    else $error("file write missing");
  a_we_cause: assert property (o_file_we |-> $past(tk, 3) && $past(i_instr[15:9], 3) == 7'h0d)
    else $error("file write without cause");
  a_access_bank: assert property (tk && !i_instr[8] && (i_instr[15:9] == 7'h33
      || i_instr[15:10] == 6'h06) |=> o_file_addr == {{4{$past(i_instr[7])}}, $past(i_instr[7:0])})
    else $error("access bank address wrong");
endmodule
bind table_xor_exec table_xor_exec_chk table_xor_exec_chk_inst (.i_clk, .i_rst, .i_rd,
  .i_instr_valid, .i_instr, .i_instr_two_word, .i_file_rdata, .o_instr_ready, .o_discard,
  .o_rdata, .o_file_addr, .o_file_we);

// [dv/table_xor_exec_tb_top.sv]
`timescale 1ns/10ps
// ====================================
// testbench
module table_xor_exec_tb_top;
  logic        i_clk, i_rst, i_wr, i_rd, i_tw, rdy, dis, we, d, ce;
  logic [4:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, fr, fw, w, k, v, em, lt, stv, hold [8];
  logic [15:0] i_instr;
  logic [11:0] fa, ea;
  logic [20:0] ptr;
  logic [31:0] s;
  logic [1:0]  tm;
  int          error_cnt, checked, cyc;
  table_xor_exec table_xor_exec_inst (.i_clk, .i_rst, .i_ce(ce), .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_instr_valid(1'b1), .i_instr, .i_instr_two_word(i_tw),
    .o_instr_ready(rdy), .o_discard(dis), .i_file_rdata(fr), .o_file_addr(fa),
    .o_file_we(we), .o_file_wdata(fw));
  data_mem_model data_mem_model_inst (.i_clk, .i_addr(fa), .i_we(we), .i_wdata(fw),
    .o_rdata(fr));
  // ====================================
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] st(input logic [7:0] r);
    return {6'h00, r[7], r == 8'h00};
  endfunction
  // bank select is fixed at 3 by the bench
  function automatic logic [11:0] fad(input logic [7:0] f, input logic a);
    return a ? {4'h3, f} : {{4{f[7]}}, f};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= x;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    cmp(o_rdata, e);
    @(posedge i_clk);
  endtask
  // the word is held until the edge that takes it; discard is seen in that cycle
  task automatic exe(input logic [15:0] x, input logic t, output logic dd);
    i_instr <= x;
    i_tw <= t;
    do @(negedge i_clk); while (rdy !== 1'b1);
    dd = dis;
    @(posedge i_clk);
  endtask
  // ====================================
  // clock, timeout, sequence
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    {i_rst, i_wr, i_rd, i_tw, i_addr, i_wdata, i_instr} = {4'h8, 29'h0};
    {w, stv, lt, ea, em, tm, s, ptr} = {46'h0, 32'h5dfc, 21'h1ffffd};
    foreach (hold[j]) hold[j] = 8'h00;
    ce = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    data_mem_model_inst.mem[0] = 8'h00;
    wr(5'h00, 8'hff);
    wr(5'h08, 8'hfd);
    wr(5'h09, 8'hff);
    wr(5'h0a, 8'h1f);
    wr(5'h0e, 8'h03);
    rd(5'h1f, 8'h00);
    for (int i = 0; i < 40; i++) begin
      s = nx(s);
      k = s[15:8];
      case (s[1:0])
        2'd0: begin
          exe({8'h0a, k}, 1'b0, d);
          w = w ^ k;
          stv = st(w);
        end
        2'd1: begin
          ea = fad(k, s[8]);
          data_mem_model_inst.mem[ea] = s[23:16];
          v = w ^ s[23:16];
          exe({6'h06, s[9], s[8], k}, 1'b0, d);
          stv = st(v);
          em = s[9] ? v : s[23:16];
          if (!s[9]) w = v;
        end
        2'd2: begin
          lt = k;
          wr(5'h0b, k);
          if (tm == 2'd3) ptr++;
          hold[ptr[2:0]] = k;
          if (tm == 2'd1) ptr++;
          if (tm == 2'd2) ptr--;
          exe({14'h0003, tm}, 1'b0, d);
          tm++;
        end
        default: begin
          ea = fad(k, s[8]);
          em = s[9] ? 8'h00 : s[23:16] | 8'h01;
          data_mem_model_inst.mem[ea] = em;
          exe({7'h33, s[8], k}, 1'b0, d);
          exe({8'h0a, s[31:24]}, s[9] & s[10], d);
          cmp({7'h0, d}, {7'h0, s[9]});
          if (!s[9]) w = w ^ s[31:24];
          if (!s[9]) stv = st(w);
          if (s[9] & s[10]) begin
            exe({8'h0a, s[30:23]}, 1'b0, d);
            cmp({7'h0, d}, 8'h01);
          end
        end
      endcase
      exe(16'h0000, 1'b0, d);
      // with the enable low a software write must not land
      if (s[7:5] == 3'h0) begin
        ce <= 1'b0;
        wr(5'h0c, ~w);
        ce <= 1'b1;
      end
      rd(5'h0c, w);
      rd(5'h0d, stv);
      rd(5'h08, ptr[7:0]);
      rd(5'h09, ptr[15:8]);
      rd(5'h0a, {3'h0, ptr[20:16]});
      rd(5'h0b, lt);
      for (int j = 0; j < 8; j++) rd(j[4:0], hold[j]);
      cmp(data_mem_model_inst.mem[ea], em);
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule

// [hw/table_xor_consts.svh]
`ifndef TABLE_XOR_CONSTS_SVH
`define TABLE_XOR_CONSTS_SVH

// ====================================================================
// opcode patterns
`define OPC_TBLWR_HI   14'h0003
`define OPC_TST_HI     7'h33
`define OPC_XORL_HI    8'h0a
`define OPC_XORF_HI    6'h06

// ====================================================================
// table pointer modes
`define PM_NONE        2'h0
`define PM_POSTINC     2'h1
`define PM_POSTDEC     2'h2
`define PM_PREINC      2'h3
`define PTR_STEP       21'h000001

// ====================================================================
// access bank split
`define ACC_LIMIT      8'h80
`define ACC_LO_BANK    4'h0
`define ACC_HI_BANK    4'hf

// ====================================================================
// register map, one byte per address
`define RA_HOLD0       5'h00
`define RA_HOLD7       5'h07
`define RA_PTR_LO      5'h08
`define RA_PTR_HI      5'h09
`define RA_PTR_UP      5'h0a
`define RA_LATCH       5'h0b
`define RA_WREG        5'h0c
`define RA_STATUS      5'h0d
`define RA_BANK        5'h0e

// ====================================================================
// status bits
`define ST_ZERO        0
`define ST_NEG         1
`define BYTE_ZERO      8'h00
`define RES_SIGN       7

`endif

// [hw/table_xor_exec.sv]
// What this block does
// - table write decoded when upper twelve bits zero then 11; low two bits mode
// - mode 0 keep, 1 post-increment, 2 post-decrement, 3 pre-increment pointer
// - pointer low three bits pick one of eight holding registers for latch byte
// - table pointer is a 21-bit byte address
// - pointer bit zero picks low or high byte of a program word
// - pre-increment steps before the write; post modes write old pointer; latch kept
// - test-and-skip decoded from 0110011, access bit, 8-bit file address
// - zero operand discards prefetched next word, runs a no-op cycle instead
// - skipped two-word instruction makes two cycles, both words no-ops
// - access bit 0 forces access bank, 1 uses bank select register
// - xor literal decoded from high byte 00001010; w xor literal into w
// - xor ops change only negative and zero; others change no flags
// - xor file decoded from 000110, dest bit, access bit, 8-bit address
// - dest 0 writes w, dest 1 writes the file register back
`timescale 1ns/10ps
`include "table_xor_consts.svh"

module table_xor_exec
  import table_xor_pkg::*;
#(
  parameter int HOLD_DEPTH = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [4:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  input  wire logic        i_instr_two_word,
  output logic             o_instr_ready,
  output logic             o_discard,
  input  wire logic [7:0]  i_file_rdata,
  output logic      [11:0] o_file_addr,
  output logic             o_file_we,
  output logic      [7:0]  o_file_wdata
);

  // ==================================================================
  // state

  state_t s_q;
  state_t s_d;

  logic        take;
  logic        skipping;
  logic [7:0]  x_val;
  logic [7:0]  xor_src;
  logic [7:0]  bank_byte;
  logic [2:0]  hold_idx;

  // decode of the offered word
  logic        dec_tblwr;
  logic        dec_tst;
  logic        dec_xorl;
  logic        dec_xorf;
  logic        acc_low;
  logic [11:0] acc_faddr;

  // software port address hits
  logic        hit_hold;
  logic        hit_ptr_lo;
  logic        hit_ptr_hi;
  logic        hit_ptr_up;
  logic        hit_latch;
  logic        hit_wreg;
  logic        hit_status;
  logic        hit_bank;

  // pointer steps and result flags
  logic        tbl_pre;
  logic        xorf_store;
  logic [20:0] ptr_inc;
  logic [20:0] ptr_dec;
  logic        res_zero;
  logic        res_neg;

  // ==================================================================
  // fetch handshake

  // a word is only taken in quarter one; the second table write cycle
  // stalls fetch so the prefetched word survives it
  assign o_instr_ready = i_ce && (s_q.q == Q1) && (s_q.cyc != CY_TBL2);
  assign take          = o_instr_ready && i_instr_valid;
  assign skipping      = (s_q.cyc == CY_SKIP1) || (s_q.cyc == CY_SKIP2);
  assign o_discard     = take && skipping;

  assign o_rdata      = s_q.rdata;
  assign o_file_addr  = s_q.faddr;
  assign o_file_we    = s_q.file_we;
  assign o_file_wdata = s_q.file_wdata;

  // ==================================================================
  // instruction decode

  assign dec_tblwr = (i_instr[15:2] == `OPC_TBLWR_HI);
  assign dec_tst   = (i_instr[15:9] == `OPC_TST_HI);
  assign dec_xorl  = (i_instr[15:8] == `OPC_XORL_HI);
  assign dec_xorf  = (i_instr[15:10] == `OPC_XORF_HI);

  // access bank: low half of bank 0 below the split, high half of bank 15 above
  assign acc_low   = (i_instr[7:0] < `ACC_LIMIT);
  assign acc_faddr = acc_low ? {`ACC_LO_BANK, i_instr[7:0]}
                             : {`ACC_HI_BANK, i_instr[7:0]};

  // ==================================================================
  // software port decode

  assign hit_hold   = (i_addr <= `RA_HOLD7);
  assign hit_ptr_lo = (i_addr == `RA_PTR_LO);
  assign hit_ptr_hi = (i_addr == `RA_PTR_HI);
  assign hit_ptr_up = (i_addr == `RA_PTR_UP);
  assign hit_latch  = (i_addr == `RA_LATCH);
  assign hit_wreg   = (i_addr == `RA_WREG);
  assign hit_status = (i_addr == `RA_STATUS);
  assign hit_bank   = (i_addr == `RA_BANK);

  // ==================================================================
  // execute helpers

  assign xor_src    = (s_q.op == K_XORL) ? s_q.lit : s_q.opnd;
  assign tbl_pre    = (s_q.op == K_TBLWR) && (s_q.cyc == CY_EXEC)
                      && (s_q.pmode == `PM_PREINC);
  assign xorf_store = (s_q.op == K_XORF) && s_q.dest;

  // the pointer wraps at its own width in both directions
  assign ptr_inc    = s_q.ptr + `PTR_STEP;
  assign ptr_dec    = s_q.ptr - `PTR_STEP;
  assign res_zero   = (s_q.res == `BYTE_ZERO);
  assign res_neg    = s_q.res[`RES_SIGN];

  // ==================================================================
  // next state

  always_comb begin
    s_d        = s_q;
    s_d.rdata  = 8'h00;
    s_d.file_we = 1'b0;
    x_val      = s_q.w ^ xor_src;
    hold_idx   = s_q.ptr[2:0];
    bank_byte  = {4'h0, s_q.bank};

    // software port, the core overrides it later in the same cycle
    if (i_wr) begin
      if (hit_ptr_lo) begin
        s_d.ptr[7:0] = i_wdata;
      end
      if (hit_ptr_hi) begin
        s_d.ptr[15:8] = i_wdata;
      end
      if (hit_ptr_up) begin
        s_d.ptr[20:16] = i_wdata[4:0];
      end
      if (hit_latch) begin
        s_d.latch = i_wdata;
      end
      if (hit_wreg) begin
        s_d.w = i_wdata;
      end
      if (hit_status) begin
        s_d.z = i_wdata[`ST_ZERO];
        s_d.n = i_wdata[`ST_NEG];
      end
      if (hit_bank) begin
        s_d.bank = i_wdata[3:0];
      end
    end

    // holding registers are read only; unmapped reads give zero
    if (i_rd) begin
      if (hit_hold) begin
        s_d.rdata = s_q.hold[i_addr[2:0]];
      end else if (hit_ptr_lo) begin
        s_d.rdata = s_q.ptr[7:0];
      end else if (hit_ptr_hi) begin
        s_d.rdata = s_q.ptr[15:8];
      end else if (hit_ptr_up) begin
        s_d.rdata = {3'h0, s_q.ptr[20:16]};
      end else if (hit_latch) begin
        s_d.rdata = s_q.latch;
      end else if (hit_wreg) begin
        s_d.rdata = s_q.w;
      end else if (hit_status) begin
        s_d.rdata = {6'h00, s_q.n, s_q.z};
      end else if (hit_bank) begin
        s_d.rdata = bank_byte;
      end
    end

    unique case (s_q.q)
      Q1: begin
        s_d.q = Q2;
        unique case (s_q.cyc)
          CY_EXEC: begin
            s_d.op    = K_NOP;
            s_d.pmode = i_instr[1:0];
            s_d.dest  = i_instr[9];
            s_d.lit   = i_instr[7:0];
            if (!i_instr[8]) begin
              s_d.faddr = acc_faddr;
            end else begin
              s_d.faddr = {s_q.bank, i_instr[7:0]};
            end
            if (take) begin
              if (dec_tblwr) begin
                s_d.op = K_TBLWR;
              end else if (dec_tst) begin
                s_d.op = K_TST;
              end else if (dec_xorl) begin
                s_d.op = K_XORL;
              end else if (dec_xorf) begin
                s_d.op = K_XORF;
              end
            end
          end
          CY_TBL2: begin
            s_d.op = K_TBLWR;
          end
          CY_SKIP1: begin
            s_d.op        = K_NOP;
            s_d.skip_more = take && i_instr_two_word;
          end
          CY_SKIP2: begin
            s_d.op = K_NOP;
          end
        endcase
      end

      Q2: begin
        s_d.q = Q3;
        // file read or table latch read happens in this quarter
        if (s_q.cyc == CY_TBL2) begin
          s_d.opnd = s_q.latch;
        end else begin
          s_d.opnd = i_file_rdata;
        end
      end

      Q3: begin
        s_d.q   = Q4;
        s_d.res = x_val;
        if (tbl_pre) begin
          s_d.ptr = ptr_inc;
        end
        if (xorf_store) begin
          s_d.file_we    = 1'b1;
          s_d.file_wdata = x_val;
        end
      end

      Q4: begin
        s_d.q   = Q1;
        s_d.cyc = CY_EXEC;
        unique case (s_q.op)
          K_XORL: begin
            s_d.w = s_q.res;
            s_d.z = res_zero;
            s_d.n = res_neg;
          end
          K_XORF: begin
            if (!s_q.dest) begin
              s_d.w = s_q.res;
            end
            s_d.z = res_zero;
            s_d.n = res_neg;
          end
          K_TST: begin
            // flags are left alone here
            if (s_q.opnd == `BYTE_ZERO) begin
              s_d.cyc = CY_SKIP1;
            end
          end
          K_TBLWR: begin
            if (s_q.cyc == CY_EXEC) begin
              s_d.cyc = CY_TBL2;
            end else begin
              // bit zero of the index is the byte lane within the word
              s_d.hold[hold_idx] = s_q.opnd;
              if (s_q.pmode == `PM_POSTINC) begin
                s_d.ptr = ptr_inc;
              end else if (s_q.pmode == `PM_POSTDEC) begin
                s_d.ptr = ptr_dec;
              end
            end
          end
          K_NOP: begin
            if ((s_q.cyc == CY_SKIP1) && s_q.skip_more) begin
              s_d.cyc = CY_SKIP2;
            end
          end
          default: begin
            s_d.cyc = CY_EXEC;
          end
        endcase
      end
    endcase
  end

  // ==================================================================
  // registers

  // clock enable low freezes everything, the software port included
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

endmodule

// [hw/table_xor_pkg.sv]
package table_xor_pkg;

  // ==================================================================
  // types

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } quarter_t;

  typedef enum logic [1:0] {
    CY_EXEC  = 2'b00,
    CY_TBL2  = 2'b01,
    CY_SKIP1 = 2'b11,
    CY_SKIP2 = 2'b10
  } cycle_t;

  typedef enum logic [2:0] {
    K_NOP   = 3'h0,
    K_TBLWR = 3'h1,
    K_TST   = 3'h2,
    K_XORL  = 3'h3,
    K_XORF  = 3'h4
  } op_t;

  typedef struct packed {
    quarter_t        q;
    cycle_t          cyc;
    op_t             op;
    logic [1:0]      pmode;
    logic            dest;
    logic            skip_more;
    logic [11:0]     faddr;
    logic [7:0]      lit;
    logic [7:0]      opnd;
    logic [7:0]      res;
    logic [20:0]     ptr;
    logic [7:0]      latch;
    logic [7:0]      w;
    logic            z;
    logic            n;
    logic [3:0]      bank;
    logic [7:0][7:0] hold;
    logic [7:0]      rdata;
    logic            file_we;
    logic [7:0]      file_wdata;
  } state_t;

endpackage
